/* core/acsp_pkg.sv */
// Purpose: shared constants and types for the auxiliary control/status port
// Assumes: 25 MHz system clock
// Notes:   offsets are byte addresses on the AXI4-Lite register bus
package acsp_pkg;

  // ---------------------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned HB_FREQ_HZ     = 1;
  localparam int unsigned HB_HALF_CYC    = CLK_HZ / (2 * HB_FREQ_HZ);
  localparam int unsigned DEB_TIME_US    = 10_000;
  localparam int unsigned DEB_CYC        = (CLK_HZ / 1_000_000) * DEB_TIME_US;
  localparam int unsigned BAUD           = 38_400;
  localparam int unsigned BAUD_DIV       = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int unsigned BOX_STEP_US    = 100_000;
  localparam int unsigned BOX_STEP_CYC   = (CLK_HZ / 1_000_000) * BOX_STEP_US;
  localparam int unsigned BOX_STEPS      = 4;

  localparam int unsigned NUM_SNAP       = 5;
  localparam int unsigned NUM_CONTACT    = 7;
  localparam int unsigned SNAP_W         = 3;
  localparam int unsigned NUM_OUT        = 4;
  localparam int unsigned LAT_W          = 16;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_SNAP_REQ  = 8'h08;
  localparam logic [7:0] OFS_INCIDENT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h18;
  localparam logic [7:0] OFS_LAT_BASE  = 8'h20;
  localparam logic [7:0] OFS_PAD_BASE  = 8'h30;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ctrl bits
  localparam int unsigned CTRL_OPER    = 0;
  localparam int unsigned CTRL_SER485  = 1;
  localparam int unsigned CTRL_SLP_CLR = 2;

  // irq bits
  localparam int unsigned IRQ_SNAP     = 0;
  localparam int unsigned IRQ_MUTE     = 1;
  localparam int unsigned IRQ_SLEEP    = 2;
  localparam int unsigned IRQ_REFUSED  = 3;
  localparam int unsigned IRQ_W        = 4;

  typedef enum logic [1:0] {
    INC_OK    = 2'b00,
    INC_CHECK = 2'b01,
    INC_FAULT = 2'b10
  } acsp_incident_e;

  typedef struct packed {
    logic              valid;
    logic [SNAP_W-1:0] num;
  } acsp_recall_s;

  typedef struct packed {
    logic [3:0] box;
    logic [4:0] num;
  } acsp_ind_s;

endpackage

/* core/acsp_port.sv */
// Purpose: auxiliary contact inputs, relays, heartbeat and snapshot recall
// Assumes: single clock, synchronous active-high reset, AXI4-Lite registers
// Notes:   contact inputs are active low; relays are energise-high
//
// Functional notes
// - contact X grounded mutes outputs
// - contact Y grounded enters deep sleep
// - snapshot input n grounded recalls snapshot n
// - grounded snapshot port blocks software recalls
// - recall accepted from both sources, snapshot inputs and software
// - recall triggers component recall, not module parameters
// - snapshot change starts box pattern, shows number
// - fault relay energised unless fault or unpowered
// - check relay energised unless check or unpowered
// - heartbeat 1 Hz while operating correctly
// - serial link 38.4k baud, one phy only
// - pad outputs to equal latency per module
// - equalisation confined to one drive module
// - incident level fault, check or ok
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module acsp_port
  import acsp_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEB_CYC,
  parameter int unsigned HB_CYCLES  = HB_HALF_CYC,
  parameter int unsigned BOX_CYCLES = BOX_STEP_CYC
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // contact inputs, active low: [0]=mute X, [1]=sleep Y, [6:2]=snapshots 1..5
  input  wire logic [NUM_CONTACT-1:0]  contact_n,
  // device outputs
  output logic                         mute_out,
  output logic                         sleep_out,
  output logic                         fault_relay,
  output logic                         check_relay,
  output logic                         heartbeat_out,
  output acsp_ind_s                    indicators,
  output acsp_recall_s                 component_recall,
  output logic                         ser_rs485_sel,
  output logic [15:0]                  ser_baud_div,
  output logic [NUM_OUT*LAT_W-1:0]     pad_delay,
  output logic                         irq,
  // axi4-lite slave
  input  wire logic [7:0]              s_awaddr,
  input  wire logic                    s_awvalid,
  output logic                         s_awready,
  input  wire logic [31:0]             s_wdata,
  input  wire logic [3:0]              s_wstrb,
  input  wire logic                    s_wvalid,
  output logic                         s_wready,
  output logic [1:0]                   s_bresp,
  output logic                         s_bvalid,
  input  wire logic                    s_bready,
  input  wire logic [7:0]              s_araddr,
  input  wire logic                    s_arvalid,
  output logic                         s_arready,
  output logic [31:0]                  s_rdata,
  output logic [1:0]                   s_rresp,
  output logic                         s_rvalid,
  input  wire logic                    s_rready
);

  // ---------------------------------------------------------------------------
  // contact synchronise and debounce
  // ---------------------------------------------------------------------------
  logic [NUM_CONTACT-1:0] sync1_reg, sync2_reg, deb_reg, deb_prev_reg;
  logic [23:0]            deb_cnt_reg [NUM_CONTACT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= contact_n;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      deb_reg      <= '1;
      deb_prev_reg <= '1;
      for (int i = 0; i < NUM_CONTACT; i++) deb_cnt_reg[i] <= '0;
    end else begin
      deb_prev_reg <= deb_reg;
      for (int i = 0; i < NUM_CONTACT; i++) begin
        if (sync2_reg[i] == deb_reg[i]) begin
          deb_cnt_reg[i] <= '0;
        end else if (deb_cnt_reg[i] >= 24'(DEB_CYCLES - 1)) begin
          deb_reg[i]     <= sync2_reg[i];
          deb_cnt_reg[i] <= '0;
        end else begin
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 24'h000001;
        end
      end
    end
  end

  logic [NUM_SNAP-1:0] snap_low, snap_fall;
  assign snap_low  = ~deb_reg[NUM_CONTACT-1:2];
  assign snap_fall = snap_low & deb_prev_reg[NUM_CONTACT-1:2];

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [2:0]          ctrl_reg;
  logic [1:0]          incident_reg;
  logic [IRQ_W-1:0]    irq_stat_reg, irq_en_reg;
  logic [LAT_W-1:0]    lat_reg [NUM_OUT];
  logic [SNAP_W-1:0]   snap_cur_reg;
  logic                sleep_reg;
  logic                sw_req;
  logic [SNAP_W-1:0]   sw_num;

  // ---------------------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------------------
  logic       aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic       wr_go;

  assign s_awready = !aw_have_reg && !s_bvalid;
  assign s_wready  = !w_have_reg && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_go     = aw_have_reg && w_have_reg && !s_bvalid;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      s_bvalid    <= 1'b0;
      s_bresp     <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_wdata;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        s_bvalid    <= 1'b1;
        s_bresp     <= wr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_known(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_SNAP_REQ || a == OFS_INCIDENT ||
           a == OFS_IRQ_EN || a == OFS_IRQ_CLR ||
           (a[7:4] == OFS_LAT_BASE[7:4] && a[1:0] == 2'h0);
  endfunction

  assign sw_req = wr_go && aw_addr_reg == OFS_SNAP_REQ;
  assign sw_num = w_data_reg[SNAP_W-1:0];

  // byte-lane writes are accepted whole; all fields sit in the low byte or two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg     <= 3'h0;
      incident_reg <= INC_OK;
      irq_en_reg   <= '0;
      for (int i = 0; i < NUM_OUT; i++) lat_reg[i] <= '0;
    end else if (wr_go) begin
      case (aw_addr_reg)
        OFS_CTRL:     ctrl_reg   <= w_data_reg[2:0];
        OFS_INCIDENT: incident_reg <= (w_data_reg[1:0] == 2'h3) ? INC_FAULT
                                                                : w_data_reg[1:0];
        OFS_IRQ_EN:   irq_en_reg <= w_data_reg[IRQ_W-1:0];
        default: begin
          if (aw_addr_reg[7:4] == OFS_LAT_BASE[7:4])
            lat_reg[aw_addr_reg[3:2]] <= w_data_reg[LAT_W-1:0];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= RESP_OKAY;
      case (s_araddr)
        OFS_CTRL:     s_rdata <= {29'h0, ctrl_reg};
        OFS_STATUS:   s_rdata <= {21'h0, ~deb_reg, sleep_reg, snap_cur_reg};
        OFS_INCIDENT: s_rdata <= {30'h0, incident_reg};
        OFS_IRQ_STAT: s_rdata <= {28'h0, irq_stat_reg};
        OFS_IRQ_EN:   s_rdata <= {28'h0, irq_en_reg};
        default: begin
          s_rdata <= '0;
          if (s_araddr[7:4] == OFS_LAT_BASE[7:4] && s_araddr[1:0] == 2'h0)
            s_rdata <= {16'h0, lat_reg[s_araddr[3:2]]};
          else if (s_araddr[7:4] == OFS_PAD_BASE[7:4] && s_araddr[1:0] == 2'h0)
            s_rdata <= {16'h0, pad_delay[s_araddr[3:2]*LAT_W +: LAT_W]};
          else if (s_araddr != OFS_SNAP_REQ && s_araddr != OFS_IRQ_CLR)
            s_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // snapshot recall arbitration
  // ---------------------------------------------------------------------------
  logic [SNAP_W-1:0] port_num;
  logic              sw_ok, sw_refused;

  always_comb begin
    port_num = '0;
    for (int i = NUM_SNAP - 1; i >= 0; i--)
      if (snap_fall[i]) port_num = SNAP_W'(i + 1);
  end

  assign sw_ok      = sw_req && snap_low == '0 && sw_num >= 3'h1 && sw_num <= 3'(NUM_SNAP);
  assign sw_refused = sw_req && !sw_ok;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snap_cur_reg     <= '0;
      component_recall <= '0;
    end else begin
      component_recall.valid <= 1'b0;
      if (port_num != '0) begin
        snap_cur_reg     <= port_num;
        component_recall <= '{valid: 1'b1, num: port_num};
      end else if (sw_ok) begin
        snap_cur_reg     <= sw_num;
        component_recall <= '{valid: 1'b1, num: sw_num};
      end
    end
  end

  logic snap_change;
  assign snap_change = (port_num != '0 && port_num != snap_cur_reg) ||
                       (port_num == '0 && sw_ok && sw_num != snap_cur_reg);

  // ---------------------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------------------
  logic [23:0] box_cnt_reg;
  logic [2:0]  box_step_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      box_cnt_reg  <= '0;
      box_step_reg <= '0;
    end else if (snap_change) begin
      box_cnt_reg  <= '0;
      box_step_reg <= 3'(BOX_STEPS);
    end else if (box_step_reg != '0) begin
      if (box_cnt_reg >= 24'(BOX_CYCLES - 1)) begin
        box_cnt_reg  <= '0;
        box_step_reg <= box_step_reg - 3'h1;
      end else begin
        box_cnt_reg <= box_cnt_reg + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      indicators <= '0;
    end else begin
      indicators.box <= (box_step_reg == '0) ? 4'h0
                        : 4'((6'h20 >> box_step_reg) - 6'h1);
      indicators.num <= 5'((6'h1 << snap_cur_reg) - 6'h1);
    end
  end

  // ---------------------------------------------------------------------------
  // mute, sleep, relays, heartbeat
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mute_out  <= 1'b0;
      sleep_reg <= 1'b0;
    end else begin
      mute_out <= ~deb_reg[0];
      if (~deb_reg[1] && deb_prev_reg[1])
        sleep_reg <= 1'b1;
      else if (wr_go && aw_addr_reg == OFS_CTRL && w_data_reg[CTRL_SLP_CLR])
        sleep_reg <= 1'b0;
    end
  end
  assign sleep_out = sleep_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_relay <= 1'b0;
      check_relay <= 1'b0;
    end else begin
      fault_relay <= ctrl_reg[CTRL_OPER] && incident_reg != INC_FAULT;
      check_relay <= ctrl_reg[CTRL_OPER] && incident_reg != INC_CHECK;
    end
  end

  logic [23:0] hb_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hb_cnt_reg    <= '0;
      heartbeat_out <= 1'b0;
    end else if (ctrl_reg[CTRL_OPER] && incident_reg != INC_FAULT) begin
      if (hb_cnt_reg >= 24'(HB_CYCLES - 1)) begin
        hb_cnt_reg    <= '0;
        heartbeat_out <= ~heartbeat_out;
      end else begin
        hb_cnt_reg <= hb_cnt_reg + 24'h000001;
      end
    end
  end

  assign ser_rs485_sel = ctrl_reg[CTRL_SER485];
  assign ser_baud_div  = 16'(BAUD_DIV);

  // ---------------------------------------------------------------------------
  // latency equalisation for one drive module
  // ---------------------------------------------------------------------------
  function automatic logic [LAT_W-1:0] max_lat(input logic [LAT_W-1:0] a, b);
    return (a > b) ? a : b;
  endfunction

  logic [LAT_W-1:0] lat_max;
  always_comb begin
    lat_max = '0;
    for (int i = 0; i < NUM_OUT; i++) lat_max = max_lat(lat_max, lat_reg[i]);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) pad_delay <= '0;
    else for (int i = 0; i < NUM_OUT; i++)
      pad_delay[i*LAT_W +: LAT_W] <= lat_max - lat_reg[i];
  end

  // ---------------------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set, irq_clr;
  assign irq_set = {sw_refused, ~deb_reg[1] & deb_prev_reg[1],
                    ~deb_reg[0] & deb_prev_reg[0], component_recall.valid};
  assign irq_clr = (wr_go && aw_addr_reg == OFS_IRQ_CLR) ? w_data_reg[IRQ_W-1:0] : '0;

  // set wins over clear
  always_ff @(posedge clk_sys) begin
    if (rst) irq_stat_reg <= '0;
    else     irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
  end
  assign irq = |(irq_stat_reg & irq_en_reg);

endmodule // acsp_port

/* verif/acsp_port_asserts.sv */
// Purpose: concurrent checks on the aux control/status port pins
// Assumes: contacts idle high; short debounce and heartbeat counts
// Notes:   bound to every acsp_port instance
`timescale 1ns/1ps
module acsp_port_asserts
  import acsp_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = 4,
  parameter int unsigned HB_CYCLES  = 8
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst,
  // contacts and device outputs
  input wire logic [NUM_CONTACT-1:0] contact_n,
  input wire logic                   mute_out,
  input wire logic                   sleep_out,
  input wire logic                   fault_relay,
  input wire logic                   heartbeat_out,
  input wire acsp_ind_s              indicators,
  input wire acsp_recall_s           component_recall,
  // bus handshakes
  input wire logic                   s_awvalid,
  input wire logic                   s_awready,
  input wire logic                   s_wvalid,
  input wire logic                   s_wready,
  input wire logic                   s_bvalid,
  input wire logic                   s_bready,
  input wire logic [1:0]             s_bresp,
  input wire logic                   s_rvalid,
  input wire logic                   s_rready,
  input wire logic [31:0]            s_rdata
);
  // ----
  // helper counters
  // ----
  // margin past sync and debounce so bounce never reaches a check
  localparam logic [7:0] LONG = 8'(DEB_CYCLES + 8);
  logic [7:0]  lo_cnt [NUM_CONTACT];
  logic [7:0]  hi0_cnt;
  logic [15:0] hb_run;
  logic        hb_prev;
  logic        hb_seen;
  logic        held_any;
  logic [2:0]  held_num;

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_CONTACT; i++) begin
      if (rst || contact_n[i]) lo_cnt[i] <= 8'h00;
      else if (lo_cnt[i] != 8'hFF) lo_cnt[i] <= lo_cnt[i] + 8'h01;
    end
    if (rst || !contact_n[0]) hi0_cnt <= 8'h00;
    else if (hi0_cnt != 8'hFF) hi0_cnt <= hi0_cnt + 8'h01;
  end

  // a pause restarts the period check, the first toggle after it is free
  always_ff @(posedge clk_sys) begin
    hb_prev <= heartbeat_out;
    if (rst || !fault_relay) begin
      hb_run  <= 16'h0000;
      hb_seen <= 1'b0;
    end else if (heartbeat_out != hb_prev) begin
      hb_run  <= 16'h0000;
      hb_seen <= 1'b1;
    end else begin
      hb_run <= hb_run + 16'h0001;
    end
  end

  always_comb begin
    held_any = 1'b0;
    held_num = 3'h0;
    for (int i = 0; i < NUM_SNAP; i++) begin
      if (lo_cnt[i+2] >= LONG) begin
        held_any = 1'b1;
        held_num = 3'(i + 1);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_mute_on: assert property (lo_cnt[0] >= LONG |-> mute_out)
    else $error("mute missing with contact held");
  a_mute_off: assert property (hi0_cnt >= LONG |-> !mute_out)
    else $error("mute present with contact open");
  a_sleep_enter: assert property (lo_cnt[1] == LONG |-> sleep_out)
    else $error("sleep missing after contact closed");
  a_recall_pulse: assert property (component_recall.valid |=> !component_recall.valid)
    else $error("recall pulse longer than one cycle");
  a_recall_range: assert property (component_recall.valid |->
    component_recall.num >= 3'h1 && component_recall.num <= 3'h5)
    else $error("recall number out of range");
  a_port_wins: assert property (held_any && component_recall.valid |->
    component_recall.num == held_num)
    else $error("recall accepted while port held");
  a_ind_thermo: assert property (indicators.num inside
    {5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F})
    else $error("indicator number not a thermometer");
  a_hb_period: assert property (hb_seen && heartbeat_out != hb_prev |->
    hb_run == 16'(HB_CYCLES - 1))
    else $error("heartbeat half period wrong");
  a_hb_hold: assert property (!fault_relay ##1 !fault_relay |-> $stable(heartbeat_out))
    else $error("heartbeat toggles while not operating");
  a_write_resp: assert property (s_awvalid && s_awready && s_wvalid && s_wready |->
    ##[1:3] s_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
endmodule // acsp_port_asserts

bind acsp_port acsp_port_asserts #(.DEB_CYCLES(DEB_CYCLES), .HB_CYCLES(HB_CYCLES))
  u_acsp_port_asserts (.clk_sys, .rst, .contact_n, .mute_out, .sleep_out, .fault_relay,
  .heartbeat_out, .indicators, .component_recall, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bvalid, .s_bready, .s_bresp, .s_rvalid, .s_rready, .s_rdata);

/* verif/acsp_contact_model.sv */
// Purpose: switch closures on the aux contact inputs
// Assumes: pull-ups hold open contacts high
// Notes:   a change chatters for three cycles before it settles
`timescale 1ns/1ps
module acsp_contact_model
  import acsp_pkg::*;
(
  // clock
  input  wire logic                   clk_sys,
  // switch state, high = closed
  input  wire logic [NUM_CONTACT-1:0] closed,
  input  wire logic                   bounce,
  // contact lines, low when grounded
  output logic      [NUM_CONTACT-1:0] contact_n
);
  logic [NUM_CONTACT-1:0] last   = '0;
  logic [NUM_CONTACT-1:0] moving = '0;
  logic [1:0]             chat   = 2'h0;

  always @(posedge clk_sys) begin
    last <= closed;
    if (bounce && closed != last) begin
      moving    <= closed ^ last;
      chat      <= 2'h3;
      contact_n <= ~last ^ (closed ^ last);
    end else if (chat != 2'h0) begin
      contact_n <= contact_n ^ moving;
      chat      <= chat - 2'h1;
    end else begin
      contact_n <= ~closed;
    end
  end
endmodule // acsp_contact_model

/* verif/acsp_port_tb_top.sv */
// Purpose: self-checking bench for the aux control/status port
// Assumes: short debounce, heartbeat and box counts
// Notes:   registers reached over axi4-lite only
`timescale 1ns/1ps
module acsp_port_tb_top
  import acsp_pkg::*;
();
  // ----
  // signals
  // ----
  logic                     clk_sys, rst, bounce;
  logic [NUM_CONTACT-1:0]   closed;
  wire  [NUM_CONTACT-1:0]   contact_n;
  logic                     mute_out, sleep_out, fault_relay, check_relay;
  logic                     heartbeat_out, ser_rs485_sel, irq;
  acsp_ind_s                indicators;
  acsp_recall_s             component_recall;
  logic [15:0]              ser_baud_div;
  logic [NUM_OUT*LAT_W-1:0] pad_delay;
  logic [7:0]               s_awaddr, s_araddr;
  logic [31:0]              s_wdata, s_rdata, rdat;
  logic [1:0]               s_bresp, s_rresp, rsp;
  logic                     s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic                     s_arvalid, s_arready, s_rvalid, s_rready;
  logic [2:0]               last_num;
  logic                     hb_prev;
  logic [15:0]              lat [4] = '{16'h000A, 16'h0028, 16'h0019, 16'h0028};
  int                       n_fail = 0, checks_done = 0, n_rec = 0, hb_tog = 0, base, box_seen = 0;

  acsp_port #(.DEB_CYCLES(4), .HB_CYCLES(8), .BOX_CYCLES(4)) u_acsp_port (.clk_sys, .rst,
    .contact_n, .mute_out, .sleep_out, .fault_relay, .check_relay, .heartbeat_out,
    .indicators, .component_recall, .ser_rs485_sel, .ser_baud_div, .pad_delay, .irq,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready);
  acsp_contact_model u_acsp_contact_model (.clk_sys, .closed, .bounce, .contact_n);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    hb_prev <= heartbeat_out;
    if (heartbeat_out !== hb_prev) hb_tog <= hb_tog + 1;
    if (component_recall.valid === 1'b1) begin
      n_rec    <= n_rec + 1;
      last_num <= component_recall.num;
    end
    if (indicators.box !== 4'h0) box_seen <= box_seen + 1;
  end

  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1 && n < 100);
    rsp = s_bresp;
    chk("bvalid", s_bvalid, 32'h1);
  endtask

  task automatic bus_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1 && n < 100);
    rdat = s_rdata;
    rsp  = s_rresp;
    chk("rvalid", s_rvalid, 32'h1);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    results();
  end

  // ----
  // tests
  // ----
  initial begin
    rst = 1'b1;
    bounce = 1'b1;
    closed = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_arvalid} = '0;
    // responses always accepted: no double drive between calls
    {s_bready, s_rready} = 2'h3;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("fault_rst", fault_relay, 32'h0);
    bus_wr(OFS_CTRL, 32'h3);
    chk("rs485_sel", ser_rs485_sel, 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus_wr(OFS_INCIDENT, i);
      cyc(2);
      chk("fault_relay", fault_relay, (i >= 2) ? 32'h0 : 32'h1);
      chk("check_relay", check_relay, (i == 1) ? 32'h0 : 32'h1);
      base = hb_tog;
      cyc(80);
      chk("hb_toggles", hb_tog - base, (i >= 2) ? 32'h0 : 32'hA);
    end
    bus_wr(OFS_INCIDENT, 32'h0);
    bus_wr(OFS_CTRL, 32'h1);
    $display("test relays done");
    bus_wr(OFS_IRQ_CLR, 32'hF);
    bus_wr(OFS_IRQ_EN, 32'h0);
    closed <= 7'h01;
    cyc(16);
    chk("mute_on", mute_out, 32'h1);
    chk("irq_masked", irq, 32'h0);
    bus_rd(OFS_IRQ_STAT);
    chk("irq_stat", rdat & 32'h2, 32'h2);
    bus_wr(OFS_IRQ_EN, 32'h2);
    chk("irq_on", irq, 32'h1);
    closed <= 7'h00;
    cyc(16);
    chk("mute_off", mute_out, 32'h0);
    bus_wr(OFS_IRQ_CLR, 32'h2);
    chk("irq_clr", irq, 32'h0);
    bus_wr(OFS_IRQ_EN, 32'h0);
    $display("test mute done");
    closed <= 7'h02;
    cyc(16);
    chk("sleep_on", sleep_out, 32'h1);
    bus_rd(OFS_STATUS);
    chk("status_sleep", rdat & 32'h8, 32'h8);
    closed <= 7'h00;
    cyc(16);
    bus_wr(OFS_CTRL, 32'h5);
    cyc(1);
    chk("sleep_clr", sleep_out, 32'h0);
    $display("test sleep done");
    for (int n = 1; n <= 5; n++) begin
      base = n_rec;
      closed <= 7'(1 << (n + 1));
      cyc(10);
      closed <= 7'h00;
      cyc(24);
      chk("recall_cnt", n_rec - base, 32'h1);
      chk("recall_num", last_num, n);
      chk("ind_num", indicators.num, (32'h1 << n) - 32'h1);
      chk("box_seen", box_seen, BOX_STEPS * 4 * n);
      bus_rd(OFS_STATUS);
      chk("status_snap", rdat & 32'h7, n);
    end
    $display("test port recall done");
    bus_wr(OFS_IRQ_CLR, 32'hF);
    base = n_rec;
    bus_wr(OFS_SNAP_REQ, 32'h2);
    cyc(4);
    chk("sw_recall", n_rec - base, 32'h1);
    chk("sw_num", last_num, 32'h2);
    bus_wr(OFS_SNAP_REQ, 32'h6);
    cyc(4);
    chk("sw_bad_num", n_rec - base, 32'h1);
    closed <= 7'h10;
    cyc(20);
    bus_wr(OFS_IRQ_CLR, 32'hF);
    base = n_rec;
    bus_wr(OFS_SNAP_REQ, 32'h1);
    cyc(4);
    chk("port_wins", n_rec - base, 32'h0);
    bus_rd(OFS_IRQ_STAT);
    chk("refused", rdat & 32'h8, 32'h8);
    closed <= 7'h00;
    cyc(16);
    $display("test sw recall done");
    for (int i = 0; i < 4; i++) bus_wr(OFS_LAT_BASE + 8'(4 * i), {16'h0, lat[i]});
    cyc(2);
    for (int i = 0; i < 4; i++) begin
      bus_rd(OFS_PAD_BASE + 8'(4 * i));
      chk("pad_reg", rdat, 32'h28 - lat[i]);
      chk("pad_port", pad_delay[i*16 +: 16], 32'h28 - lat[i]);
    end
    $display("test latency done");
    bus_rd(8'h40);
    chk("unmapped_rresp", rsp, RESP_SLVERR);
    chk("unmapped_rdata", rdat, 32'h0);
    bus_wr(8'h44, 32'h1);
    chk("unmapped_bresp", rsp, RESP_SLVERR);
    bus_rd(OFS_SNAP_REQ);
    chk("wo_read", rdat, 32'h0);
    chk("baud_div", ser_baud_div, 32'h28B);
    $display("test bus done");
    results();
  end
endmodule // acsp_port_tb_top
